// ### dafmt_top.sv
`timescale 1ns/1ps
`include "dafmt_cfg.svh"
module dafmt_top import dafmt_pkg::*; #(
	parameter int BITS = 12,
	parameter int PW = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic enc_pin,
	input wire logic parallel_mode_pin,
	input wire logic strap_cs_pin,
	input wire logic strap_sck_pin,
	input wire logic [BITS-1:0] ch1_sample,
	input wire logic ch1_over_range,
	input wire logic [BITS-1:0] ch2_sample,
	input wire logic ch2_over_range,
	output logic forwarded_output_clock,
	output logic forwarded_output_clock_n,
	output logic [BITS-1:0] ch1_data,
	output logic [BITS-1:0] ch2_data,
	output logic channel1_overflow_output,
	output logic channel2_overflow_output,
	output logic [BITS/2-1:0] channel1_lane,
	output logic [BITS/2-1:0] channel2_lane,
	output logic shared_overflow_output,
	output logic lvds_enable,
	output dafmt_cur_t lvds_current,
	output logic lvds_current_double,
	output logic lvds_term_en,
	output logic dcs_locked
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [3:0] clkctl_q;
	logic [5:0] outmode_q;
	logic dfmt_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 2 * BITS + 5;
	logic [SW-1:0] sy1_q, sy2_q, sy3_q, pin_q;
	logic [2*BITS+1:0] smp_q;
	logic shared_q, outclk_q, outclk_n_q;

	wire [SW-1:0] sy_in = {parallel_mode_pin, strap_cs_pin, strap_sck_pin,
		ch1_over_range, ch1_sample, ch2_over_range, ch2_sample};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
			pin_q <= '0;
		end else begin
			sy1_q <= sy_in;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			pin_q <= (pin_q & (sy2_q ^ sy3_q)) | (sy3_q & ~(sy2_q ^ sy3_q));
		end
	end

	wire par_mode = pin_q[SW-1];
	wire strap_cs = pin_q[SW-2];
	wire strap_sck = pin_q[SW-3];

	// ----------------------------------------------------------------
	// Effective configuration
	// ----------------------------------------------------------------
	wire [1:0] reg_mode = outmode_q[`DAFMT_OM_MODE_MSB:`DAFMT_OM_MODE_LSB];
	wire dcs_en = par_mode ? strap_cs : clkctl_q[`DAFMT_CLK_DCS_BIT];
	wire [1:0] phase = par_mode ? 2'h0 : clkctl_q[`DAFMT_CLK_PHASE_MSB:`DAFMT_CLK_PHASE_LSB];
	wire invert = par_mode ? 1'b0 : clkctl_q[`DAFMT_CLK_INV_BIT];
	wire twos = par_mode ? 1'b0 : dfmt_q;
	wire reg_ddr_cmos = reg_mode == DAFMT_DDR_CMOS;
	wire reg_lvds = reg_mode == DAFMT_DDR_LVDS;
	// The strap only reaches full-rate CMOS or double-rate LVDS.
	wire mode_lvds = par_mode ? strap_sck : reg_lvds;
	wire mode_ddr_cmos = ~par_mode & reg_ddr_cmos;
	wire mode_ddr = mode_lvds | mode_ddr_cmos;
	wire mode_full = ~mode_ddr;
	wire [1:0] eff_mode = mode_lvds ? DAFMT_DDR_LVDS :
		(mode_ddr_cmos ? DAFMT_DDR_CMOS : DAFMT_FULL_CMOS);
	wire [2:0] reg_cur = outmode_q[`DAFMT_OM_CUR_MSB:`DAFMT_OM_CUR_LSB];
	wire cur_ok = reg_cur != 3'h3;
	wire term = ~par_mode & outmode_q[`DAFMT_OM_TERM_BIT];

	// ----------------------------------------------------------------
	// Encode timing and channel formatting
	// ----------------------------------------------------------------
	dafmt_tm_if tm ();

	dafmt_enc_timer #(.W(PW)) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.enc_pin(enc_pin),
		.dcs_en(dcs_en),
		.phase(phase),
		.invert(invert),
		.tm(tm)
	);

	// Samples are taken at the encode edge, then presented at the clock fall.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smp_q <= '0;
		end else if (tm.enc_rise) begin
			smp_q <= pin_q[2*BITS+1:0];
		end
	end

	wire ch1_word_ovf, ch2_word_ovf;

	dafmt_chan_out #(.BITS(BITS)) u_ch1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample(smp_q[2*BITS:BITS+1]),
		.ovf(smp_q[2*BITS+1]),
		.load(tm.ck_fall),
		.twos(twos),
		.full(mode_full),
		.ddr(mode_ddr),
		.ck(tm.ck),
		.full_q(ch1_data),
		.ovf_q(channel1_overflow_output),
		.lane_q(channel1_lane),
		.word_ovf(ch1_word_ovf)
	);

	dafmt_chan_out #(.BITS(BITS)) u_ch2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample(smp_q[BITS-1:0]),
		.ovf(smp_q[BITS]),
		.load(tm.ck_fall),
		.twos(twos),
		.full(mode_full),
		.ddr(mode_ddr),
		.ck(tm.ck),
		.full_q(ch2_data),
		.ovf_q(channel2_overflow_output),
		.lane_q(channel2_lane),
		.word_ovf(ch2_word_ovf)
	);

	// The output clock is delayed one cycle to stay aligned with the lanes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shared_q <= 1'b0;
			outclk_q <= 1'b0;
			outclk_n_q <= 1'b1;
		end else begin
			shared_q <= mode_ddr & (tm.ck ? ch1_word_ovf : ch2_word_ovf);
			outclk_q <= tm.outclk;
			outclk_n_q <= ~tm.outclk;
		end
	end

	assign shared_overflow_output = shared_q;
	assign forwarded_output_clock = outclk_q;
	assign forwarded_output_clock_n = outclk_n_q;
	assign lvds_enable = mode_lvds;
	assign lvds_current = (par_mode || !cur_ok) ? DAFMT_I_3P5 : dafmt_cur_t'(reg_cur);
	assign lvds_current_double = mode_lvds & term;
	assign lvds_term_en = mode_lvds & term;
	assign dcs_locked = tm.locked;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	wire take = hsel & htrans[1] & hready;
	wire hit_clk = haddr == `DAFMT_CLKCTL_OFS;
	wire hit_om = haddr == `DAFMT_OUTMODE_OFS;
	wire hit_df = haddr == `DAFMT_DATAFMT_OFS;
	wire hit_st = haddr == `DAFMT_STATUS_OFS;
	wire [31:0] status = {16'h0, tm.period, 2'h0, eff_mode, par_mode, mode_ddr, dcs_en,
		tm.locked};
	wire [31:0] rd_sel = hit_clk ? {28'h0, clkctl_q} :
		hit_om ? {26'h0, outmode_q} :
		hit_df ? {31'h0, dfmt_q} :
		hit_st ? status : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h0;
			rdata_q <= 32'h0;
		end else begin
			wr_q <= take & hwrite;
			if (take) begin
				addr_q <= haddr;
				rdata_q <= hwrite ? 32'h0 : rd_sel;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clkctl_q <= `DAFMT_CLKCTL_RST;
			outmode_q <= `DAFMT_OUTMODE_RST;
			dfmt_q <= `DAFMT_DATAFMT_RST;
		end else if (wr_q) begin
			if (addr_q == `DAFMT_CLKCTL_OFS) begin
				clkctl_q <= hwdata[3:0];
			end else if (addr_q == `DAFMT_OUTMODE_OFS) begin
				outmode_q <= hwdata[5:0];
			end else if (addr_q == `DAFMT_DATAFMT_OFS) begin
				dfmt_q <= hwdata[`DAFMT_DF_TWOS_BIT];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
endmodule : dafmt_top

// ### dafmt_cfg.svh
`ifndef DAFMT_CFG_SVH
`define DAFMT_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DAFMT_CLKCTL_OFS 8'h00
`define DAFMT_OUTMODE_OFS 8'h04
`define DAFMT_DATAFMT_OFS 8'h08
`define DAFMT_STATUS_OFS 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DAFMT_CLK_DCS_BIT 0
`define DAFMT_CLK_PHASE_LSB 1
`define DAFMT_CLK_PHASE_MSB 2
`define DAFMT_CLK_INV_BIT 3
`define DAFMT_OM_MODE_LSB 0
`define DAFMT_OM_MODE_MSB 1
`define DAFMT_OM_CUR_LSB 2
`define DAFMT_OM_CUR_MSB 4
`define DAFMT_OM_TERM_BIT 5
`define DAFMT_DF_TWOS_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DAFMT_CLKCTL_RST 4'h0
`define DAFMT_OUTMODE_RST 6'h00
`define DAFMT_DATAFMT_RST 1'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define DAFMT_LOCK_CYCLES 7'h64
`define DAFMT_PERIOD_TOL 8'h01

`endif

// ### dafmt_pkg.sv
package dafmt_pkg;

	typedef enum logic [1:0] {
		DAFMT_FULL_CMOS = 2'h0,
		DAFMT_DDR_CMOS = 2'h1,
		DAFMT_DDR_LVDS = 2'h3
	} dafmt_mode_t;

	// Driver current steps of the LVDS outputs.
	typedef enum logic [2:0] {
		DAFMT_I_3P5 = 3'h0,
		DAFMT_I_4P0 = 3'h1,
		DAFMT_I_4P5 = 3'h2,
		DAFMT_I_3P0 = 3'h4,
		DAFMT_I_2P5 = 3'h5,
		DAFMT_I_2P1 = 3'h6,
		DAFMT_I_1P75 = 3'h7
	} dafmt_cur_t;

endpackage : dafmt_pkg

// ### dafmt_tm_if.sv
`timescale 1ns/1ps
interface dafmt_tm_if;
	logic enc_rise;
	logic ck;
	logic ck_fall;
	logic outclk;
	logic locked;
	logic [7:0] period;

	modport timer (output enc_rise, output ck, output ck_fall, output outclk, output locked,
		output period);
	modport user (input enc_rise, input ck, input ck_fall, input outclk, input locked,
		input period);
endinterface : dafmt_tm_if

// ### dafmt_enc_timer.sv
`timescale 1ns/1ps
`include "dafmt_cfg.svh"
module dafmt_enc_timer import dafmt_pkg::*; #(
	parameter int W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enc_pin,
	input wire logic dcs_en,
	input wire logic [1:0] phase,
	input wire logic invert,
	dafmt_tm_if.timer tm
);
	logic s1_q, s2_q, s3_q, lvl_q;
	logic [W-1:0] cnt_q, per_q, pos_q;
	logic [6:0] lock_q;
	logic ck_q, out_q;

	// ----------------------------------------------------------------
	// Encode pin sampling and edge detection
	// ----------------------------------------------------------------
	wire rise = s2_q & s3_q & ~lvl_q;
	wire [W-1:0] new_per = cnt_q + W'(1);
	wire [W-1:0] diff = (new_per > per_q) ? new_per - per_q : per_q - new_per;
	wire changed = diff > W'(`DAFMT_PERIOD_TOL);
	wire locked = dcs_en && (lock_q == `DAFMT_LOCK_CYCLES);
	wire [W-1:0] half = per_q >> 1;
	wire [W+1:0] sh_full = {2'h0, per_q} * {{W{1'b0}}, phase};
	wire [W-1:0] sh = locked ? W'(sh_full[W+1:3]) : '0;
	wire [W-1:0] p = (pos_q >= sh) ? pos_q - sh : pos_q + per_q - sh;
	wire ck_d = dcs_en ? (pos_q < half) : lvl_q;
	wire out_d = (dcs_en ? (p < half) : lvl_q) ^ invert;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= enc_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Period measurement, lock count and internal clock
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			per_q <= '0;
			pos_q <= '0;
			lock_q <= '0;
		end else begin
			if (rise) begin
				cnt_q <= '0;
				pos_q <= '0;
				per_q <= new_per;
				if (!dcs_en || changed) begin
					lock_q <= '0;
				end else if (lock_q != `DAFMT_LOCK_CYCLES) begin
					lock_q <= lock_q + 7'h1;
				end
			end else begin
				if (cnt_q != '1) begin
					cnt_q <= cnt_q + W'(1);
				end
				if (pos_q != '1) begin
					pos_q <= pos_q + W'(1);
				end
				if (!dcs_en) begin
					lock_q <= '0;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			ck_q <= ck_d;
			out_q <= out_d;
		end
	end

	assign tm.enc_rise = rise;
	assign tm.ck = ck_q;
	assign tm.ck_fall = ck_q & ~ck_d;
	assign tm.outclk = out_q;
	assign tm.locked = locked;
	assign tm.period = per_q;
endmodule : dafmt_enc_timer

// ### dafmt_chan_out.sv
`timescale 1ns/1ps
module dafmt_chan_out #(
	parameter int BITS = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [BITS-1:0] sample,
	input wire logic ovf,
	input wire logic load,
	input wire logic twos,
	input wire logic full,
	input wire logic ddr,
	input wire logic ck,
	output logic [BITS-1:0] full_q,
	output logic ovf_q,
	output logic [BITS/2-1:0] lane_q,
	output logic word_ovf
);
	logic [BITS-1:0] word_q;
	logic wovf_q;
	logic [BITS/2-1:0] even, odd;

	// Two's complement differs from offset binary only in the sign bit.
	wire [BITS-1:0] coded = {sample[BITS-1] ^ twos, sample[BITS-2:0]};

	always_comb begin
		for (int i = 0; i < BITS/2; i++) begin
			even[i] = word_q[2*i];
			odd[i] = word_q[2*i+1];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_q <= '0;
			wovf_q <= 1'b0;
		end else if (load) begin
			word_q <= coded;
			wovf_q <= ovf;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_q <= '0;
			ovf_q <= 1'b0;
			lane_q <= '0;
		end else begin
			full_q <= full ? word_q : '0;
			ovf_q <= full ? wovf_q : 1'b0;
			lane_q <= ddr ? (ck ? odd : even) : '0;
		end
	end

	assign word_ovf = wovf_q;
endmodule : dafmt_chan_out

// ### dafmt_top_checker.sv
`timescale 1ns/1ps
module dafmt_top_checker import dafmt_pkg::*; #(
	parameter int BITS = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic enc_pin,
	input wire logic parallel_mode_pin,
	input wire logic strap_cs_pin,
	input wire logic strap_sck_pin,
	input wire logic forwarded_output_clock,
	input wire logic forwarded_output_clock_n,
	input wire logic [BITS-1:0] ch1_data,
	input wire logic channel1_overflow_output,
	input wire logic lvds_enable,
	input wire dafmt_cur_t lvds_current,
	input wire logic lvds_current_double,
	input wire logic lvds_term_en,
	input wire logic dcs_locked
);
	logic [1:0] es_q;
	logic [7:0] ecnt_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Counts encode rises since reset; a lock can never come before a hundred of them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			es_q <= 2'h0;
			ecnt_q <= 8'h00;
		end else begin
			es_q <= {es_q[0], enc_pin};
			if (es_q == 2'h1 && ecnt_q != 8'hff) begin
				ecnt_q <= ecnt_q + 8'h01;
			end
		end
	end
	sequence s_rd_unmapped;
		hsel && htrans[1] && hready && !hwrite && haddr >= 8'h10;
	endsequence
	sequence s_strap(logic sck);
		(parallel_mode_pin && strap_sck_pin == sck) [*5];
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
	chk_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_clk_pair: assert property (forwarded_output_clock_n != forwarded_output_clock)
		else $error("clock pair not complementary");
	chk_lock_count: assert property ($rose(dcs_locked) |-> ecnt_q >= 8'h64)
		else $error("lock too early");
	chk_ddr_quiet: assert property (lvds_enable [*8] |-> ch1_data == '0 && !channel1_overflow_output)
		else $error("full rate outputs active in double rate");
	chk_strap_lvds: assert property (s_strap(1'b1) |-> lvds_enable && lvds_current == DAFMT_I_3P5 && !lvds_term_en)
		else $error("strap lvds wrong");
	chk_strap_full: assert property (s_strap(1'b0) |-> !lvds_enable)
		else $error("strap full mode wrong");
	chk_strap_dcs: assert property ((parallel_mode_pin && !strap_cs_pin) [*5] |-> !dcs_locked)
		else $error("stabilizer on while strap off");
	chk_term_double: assert property (lvds_current_double == lvds_term_en)
		else $error("current doubling wrong");
endmodule : dafmt_top_checker

bind dafmt_top dafmt_top_checker #(.BITS(BITS)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .enc_pin, .parallel_mode_pin, .strap_cs_pin,
	.strap_sck_pin, .forwarded_output_clock, .forwarded_output_clock_n, .ch1_data,
	.channel1_overflow_output, .lvds_enable, .lvds_current, .lvds_current_double, .lvds_term_en,
	.dcs_locked);

// ### dafmt_rx_model.sv
`timescale 1ns/1ps
module dafmt_rx_model (
	input wire logic hclk,
	input wire logic ddr,
	input wire logic ck,
	input wire logic [11:0] d1,
	input wire logic [11:0] d2,
	input wire logic of1,
	input wire logic of2,
	input wire logic [5:0] l1,
	input wire logic [5:0] l2,
	input wire logic ofs,
	output logic vld,
	output logic [11:0] r1,
	output logic [11:0] r2,
	output logic ro1,
	output logic ro2
);
	logic ck_q = 1'b0;
	logic [12:0] lo_q;
	logic [12:0] hi_q;
	function automatic logic [11:0] zip(input logic [5:0] ev, input logic [5:0] od);
		for (int i = 0; i < 6; i++) begin
			zip[2*i] = ev[i];
			zip[2*i+1] = od[i];
		end
	endfunction : zip
	always @(posedge hclk) begin
		ck_q <= ck;
		vld <= 1'b0;
		if (ck) begin
			hi_q <= {ofs, l2, l1};
		end else begin
			lo_q <= {ofs, l2, l1};
		end
		if (!ddr && ck && !ck_q) begin
			vld <= 1'b1;
			r1 <= d1;
			r2 <= d2;
			ro1 <= of1;
			ro2 <= of2;
		end
		if (ddr && !ck && ck_q) begin
			vld <= 1'b1;
			r1 <= zip(lo_q[5:0], hi_q[5:0]);
			r2 <= zip(lo_q[11:6], hi_q[11:6]);
			ro1 <= hi_q[12];
			ro2 <= lo_q[12];
		end
	end
endmodule : dafmt_rx_model

// ### dual_adc_output_formatter_bench.sv
`timescale 1ns/1ps
module dual_adc_output_formatter_bench import dafmt_pkg::*; ();
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, enc = 1'b0;
	logic par = 1'b0, scs = 1'b0, ssck = 1'b0, o1 = 1'b0, o2 = 1'b0, ddr_q = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [11:0] s1 = 12'h000, s2 = 12'h000, d1, d2, r1, r2;
	logic hrdy, hresp, fck, fckn, of1, of2, ofs, lven, cdbl, term, lock, vld, ro1, ro2;
	logic [5:0] l1, l2;
	dafmt_cur_t cur;
	integer seed = 62, error_cnt = 0, n_checks = 0, i, k, h, enc_hi = 80;
	always #10 hclk = ~hclk;
	// The encode period stays 160 ns whatever high time is asked for.
	initial begin
		#7;
		forever begin
			h = enc_hi;
			enc = 1'b1;
			#(h);
			enc = 1'b0;
			#(160 - h);
		end
	end
	dafmt_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
		.hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .enc_pin(enc),
		.parallel_mode_pin(par), .strap_cs_pin(scs), .strap_sck_pin(ssck),
		.ch1_sample(s1), .ch1_over_range(o1), .ch2_sample(s2), .ch2_over_range(o2),
		.forwarded_output_clock(fck), .forwarded_output_clock_n(fckn), .ch1_data(d1),
		.ch2_data(d2), .channel1_overflow_output(of1), .channel2_overflow_output(of2),
		.channel1_lane(l1), .channel2_lane(l2), .shared_overflow_output(ofs),
		.lvds_enable(lven), .lvds_current(cur), .lvds_current_double(cdbl),
		.lvds_term_en(term), .dcs_locked(lock));
	dafmt_rx_model u_rx (.hclk(hclk), .ddr(ddr_q), .ck(fck), .d1(d1), .d2(d2), .of1(of1),
		.of2(of2), .l1(l1), .l2(l2), .ofs(ofs), .vld(vld), .r1(r1), .r2(r2), .ro1(ro1), .ro2(ro2));
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task end_of_test;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task guard(input integer c, input integer lim);
		if (c >= lim) begin
			error_cnt++;
			end_of_test;
		end
	endtask : guard
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		integer n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hrdy !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hrdy !== 1'b1 && n < 50);
		rd = hrdata;
		guard(n, 50);
	endtask : xfer
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		xfer(1'b0, a, 32'h0, v);
		check(v, e);
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		xfer(1'b1, a, d, v);
	endtask : wr
	// Each random word is held three encode periods, then the receiver's last word is compared.
	task feed(input integer n, input logic tw);
		integer j, m;
		logic [31:0] r;
		for (j = 0; j < n; j++) begin
			@(negedge enc);
			@(posedge hclk);
			r = $random(seed);
			s1 <= r[11:0];
			s2 <= r[23:12];
			o1 <= r[24];
			o2 <= r[25];
			repeat (3) @(negedge enc);
			m = 0;
			while (vld !== 1'b1 && m < 40) begin
				@(posedge hclk);
				m++;
			end
			guard(m, 40);
			check(r1, tw ? s1 ^ 12'h800 : s1);
			check(r2, tw ? s2 ^ 12'h800 : s2);
			check({ro1, ro2}, {o1, o2});
			if (ddr_q) check(d1, 12'h000);
		end
	endtask : feed
	task ph(input logic [1:0] p, input logic inv, input logic dcs, input integer e);
		logic [11:0] v;
		logic c;
		wr(8'h00, {28'h0, inv, p, dcs});
		repeat (3) @(negedge enc);
		@(posedge hclk);
		s1 <= ~s1;
		v = d1;
		k = 0;
		while (d1 === v && k < 40) begin
			c = fck;
			@(posedge hclk);
			k++;
		end
		guard(k, 40);
		k = 0;
		while (!(fck === 1'b1 && c === 1'b0) && k < 40) begin
			c = fck;
			@(posedge hclk);
			k++;
		end
		guard(k, 40);
		check(k, e);
	endtask : ph
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h00, 0);
		rd(8'h04, 0);
		rd(8'h08, 0);
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 0);
		check(cur, DAFMT_I_3P5);
		$display("test registers done");
		feed(6, 1'b0);
		wr(8'h08, 32'h1);
		feed(6, 1'b1);
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h1);
		rd(8'h04, 32'h1);
		ddr_q <= 1'b1;
		feed(6, 1'b0);
		$display("test data formats done");
		for (i = 0; i < 8; i++) begin
			wr(8'h04, {26'h0, i[0], i[2:0], 2'h3});
			@(posedge hclk);
			check(lven, 1'b1);
			check(cur, i == 3 ? 0 : i);
			check({term, cdbl}, {2{i[0]}});
		end
		feed(4, 1'b0);
		// Mode code 2 falls back to full-rate CMOS.
		wr(8'h04, 32'h2);
		ddr_q <= 1'b0;
		@(posedge hclk);
		check(lven, 1'b0);
		rd(8'h0c, 32'h800);
		wr(8'h04, 32'h0);
		$display("test lvds done");
		// The 160 ns encode period is well above the stabilizer's lowest rate.
		wr(8'h00, 32'h1);
		k = 0;
		while (lock !== 1'b1 && k < 2000) begin
			@(posedge hclk);
			k++;
		end
		guard(k, 2000);
		check(lock, 1'b1);
		rd(8'h0c, 32'h803);
		// A 35% encode duty must still give a clock high for half the period.
		enc_hi = 56;
		repeat (3) @(negedge enc);
		k = 0;
		while (fck !== 1'b0 && k < 40) begin
			@(posedge hclk);
			k++;
		end
		guard(k, 40);
		k = 0;
		while (fck !== 1'b1 && k < 40) begin
			@(posedge hclk);
			k++;
		end
		guard(k, 40);
		k = 0;
		while (fck === 1'b1 && k < 40) begin
			@(posedge hclk);
			k++;
		end
		check(k, 4);
		enc_hi = 80;
		for (i = 0; i < 8; i++) ph(i[1:0], i[2], 1'b1, i[2] ? i[1:0] : 4 + i[1:0]);
		ph(2'h3, 1'b0, 1'b0, 4);
		$display("test clock phase done");
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h1);
		par <= 1'b1;
		ssck <= 1'b1;
		scs <= 1'b0;
		ddr_q <= 1'b1;
		repeat (6) @(posedge hclk);
		check({lven, lock}, 2'h2);
		feed(3, 1'b0);
		ssck <= 1'b0;
		ddr_q <= 1'b0;
		repeat (6) @(posedge hclk);
		check(lven, 1'b0);
		feed(3, 1'b0);
		scs <= 1'b1;
		k = 0;
		while (lock !== 1'b1 && k < 2000) begin
			@(posedge hclk);
			k++;
		end
		check(lock, 1'b1);
		$display("test parallel mode done");
		end_of_test;
	end
endmodule : dual_adc_output_formatter_bench
